// >>> rtl/mer_pkg.sv
// Package for the MAC error, station address and PHY management register group.
// Assumes a 32-bit Avalon-MM register bus and a single 200 MHz system clock.
package mer_pkg;
    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [11:0] OFS_ERR_FLAGS = 12'h114;
    localparam logic [11:0] OFS_ADDR_HIGH = 12'h118;
    localparam logic [11:0] OFS_ADDR_LOW = 12'h11C;
    localparam logic [11:0] OFS_MGMT_ACCESS = 12'h120;
    localparam logic [11:0] OFS_MGMT_DATA = 12'h124;

    // ------------------------------------------------------------------
    // Error flag bit positions
    // ------------------------------------------------------------------
    localparam int BIT_PHY_RX_ERR = 9;
    localparam int BIT_CHECKSUM = 8;
    localparam int BIT_OVERSIZE = 7;
    localparam int BIT_UNDERSIZE = 6;
    localparam int BIT_WATCHDOG = 5;
    localparam int BIT_EXCESS_COLL = 4;
    localparam int BIT_MISALIGNED = 3;
    localparam int BIT_UNDERRUN = 2;
    localparam int ERR_LSB = 2;
    localparam int ERR_MSB = 9;
    localparam int ERR_COUNT = 8;

    // ------------------------------------------------------------------
    // Management access fields
    // ------------------------------------------------------------------
    localparam int PHYADDR_LSB = 11;
    localparam int PHYADDR_MSB = 15;
    localparam int INDEX_LSB = 6;
    localparam int INDEX_MSB = 10;
    localparam int BIT_WRITE_NOT_READ = 1;
    localparam int BIT_BUSY = 0;
    localparam logic [4:0] PHYADDR_RESET = 5'h01;

    // ------------------------------------------------------------------
    // Reset values and sizes
    // ------------------------------------------------------------------
    localparam logic [15:0] ADDR_HIGH_BLANK = 16'hFFFF;
    localparam logic [31:0] ADDR_LOW_BLANK = 32'hFFFFFFFF;
    localparam logic [15:0] DATA_RESET = 16'h0000;
    localparam int WATCHDOG_BYTES = 11264;

    // Address image source selection
    typedef enum logic [1:0] {
        MER_SRC_NONE,
        MER_SRC_OTP,
        MER_SRC_EEPROM
    } mer_src_t;

    // Events from the MAC datapath, one-cycle pulses
    typedef struct packed {
        logic phyRxError;
        logic checksumError;
        logic oversizeFrame;
        logic undersizeFrame;
        logic watchdogExpiry;
        logic excessCollision;
        logic misalignedFrame;
        logic transmitUnderrun;
    } mer_events_t;

    // One management access as issued to the PHY engine
    typedef struct packed {
        logic [4:0] phyAddr;
        logic [4:0] regIndex;
        logic writeNotRead;
        logic [15:0] writeData;
    } mer_mgmt_req_t;
endpackage

// >>> rtl/mer_regs.sv
// Error flags, station address and PHY management access registers.
// Assumes an Avalon-MM master, a PHY management engine that pulses done,
// and address images latched before the block leaves reset.
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module mer_regs #(
    parameter int WATCHDOG_LIMIT = mer_pkg::WATCHDOG_BYTES
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [11:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire mer_pkg::mer_events_t macEvents,
    input wire logic rxFrameActive,
    input wire logic rxByteValid,
    output logic rxTruncate,
    input wire logic usbBusReset,
    input wire mer_pkg::mer_src_t addrSource,
    input wire logic [47:0] eepromAddress,
    input wire logic [47:0] otpAddress,
    output logic [47:0] stationAddress,
    output logic mgmtStart,
    output mer_pkg::mer_mgmt_req_t mgmtReq,
    input wire logic mgmtDone,
    input wire logic [15:0] mgmtReadData
);
    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    // Every access answered one cycle after it appears; simple and fixed.
    logic ackReg;
    logic accessNow;
    logic wrNow;
    logic [31:0] wmask;
    assign accessNow = (read | write) & ~ackReg;
    assign wrNow = write & ackReg;
    assign wmask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                    {8{byteenable[1]}}, {8{byteenable[0]}}};

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ackReg <= 1'b0;
        end else begin
            ackReg <= accessNow;
        end
    end

    // Registered and high while idle, so every output leaves a flop
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            waitrequest <= 1'b1;
        end else begin
            waitrequest <= ~accessNow;
        end
    end

    // ------------------------------------------------------------------
    // Error flags
    // ------------------------------------------------------------------
    logic [mer_pkg::ERR_MSB:mer_pkg::ERR_LSB] errFlags_reg;
    logic [mer_pkg::ERR_MSB:mer_pkg::ERR_LSB] errSet;
    logic [mer_pkg::ERR_MSB:mer_pkg::ERR_LSB] errClear;
    logic watchdogHit;

    always_comb begin
        errSet = '0;
        errSet[mer_pkg::BIT_PHY_RX_ERR] = macEvents.phyRxError & rxFrameActive;
        errSet[mer_pkg::BIT_CHECKSUM] = macEvents.checksumError;
        errSet[mer_pkg::BIT_OVERSIZE] = macEvents.oversizeFrame;
        errSet[mer_pkg::BIT_UNDERSIZE] = macEvents.undersizeFrame;
        errSet[mer_pkg::BIT_WATCHDOG] = macEvents.watchdogExpiry | watchdogHit;
        errSet[mer_pkg::BIT_EXCESS_COLL] = macEvents.excessCollision;
        errSet[mer_pkg::BIT_MISALIGNED] = macEvents.misalignedFrame;
        errSet[mer_pkg::BIT_UNDERRUN] = macEvents.transmitUnderrun;
        errClear = '0;
        if (wrNow && address == mer_pkg::OFS_ERR_FLAGS) begin
            errClear = writedata[mer_pkg::ERR_MSB:mer_pkg::ERR_LSB]
                       & wmask[mer_pkg::ERR_MSB:mer_pkg::ERR_LSB];
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            errFlags_reg <= '0;
        end else begin
            errFlags_reg <= (errFlags_reg & ~errClear) | errSet;
        end
    end

    // ------------------------------------------------------------------
    // Receive watchdog
    // ------------------------------------------------------------------
    logic [13:0] rxCount_reg;
    assign watchdogHit = rxFrameActive & rxByteValid & ~rxTruncate
                         & (rxCount_reg == 14'(WATCHDOG_LIMIT));

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rxCount_reg <= '0;
            rxTruncate <= 1'b0;
        end else if (!rxFrameActive) begin
            rxCount_reg <= '0;
            rxTruncate <= 1'b0;
        end else if (rxByteValid && !rxTruncate) begin
            if (watchdogHit) begin
                rxTruncate <= 1'b1;
            end else begin
                rxCount_reg <= rxCount_reg + 14'h0001;
            end
        end
    end

    // ------------------------------------------------------------------
    // Station address
    // ------------------------------------------------------------------
    logic [15:0] addrHigh_reg;
    logic [31:0] addrLow_reg;
    logic [47:0] imageAddr;
    logic imagePresent;
    logic loadDone_reg;

    always_comb begin
        case (addrSource)
            mer_pkg::MER_SRC_EEPROM: begin
                imageAddr = eepromAddress;
                imagePresent = 1'b1;
            end
            mer_pkg::MER_SRC_OTP: begin
                imageAddr = otpAddress;
                imagePresent = 1'b1;
            end
            default: begin
                imageAddr = {mer_pkg::ADDR_HIGH_BLANK, mer_pkg::ADDR_LOW_BLANK};
                imagePresent = 1'b0;
            end
        endcase
    end

    // Image taken one cycle after reset release, never under reset itself
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            loadDone_reg <= 1'b0;
            addrHigh_reg <= mer_pkg::ADDR_HIGH_BLANK;
            addrLow_reg <= mer_pkg::ADDR_LOW_BLANK;
        end else if (!loadDone_reg) begin
            loadDone_reg <= 1'b1;
            addrHigh_reg <= imageAddr[47:32];
            addrLow_reg <= imageAddr[31:0];
        end else if (usbBusReset) begin
            if (imagePresent) begin
                addrHigh_reg <= imageAddr[47:32];
            end
            addrLow_reg <= imageAddr[31:0];
        end else if (wrNow) begin
            if (address == mer_pkg::OFS_ADDR_HIGH) begin
                addrHigh_reg <= (addrHigh_reg & ~wmask[15:0])
                                | (writedata[15:0] & wmask[15:0]);
            end
            if (address == mer_pkg::OFS_ADDR_LOW) begin
                addrLow_reg <= (addrLow_reg & ~wmask) | (writedata & wmask);
            end
        end
    end

    // Octet one sits in the low byte; used for match and pause only
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            stationAddress <= {mer_pkg::ADDR_HIGH_BLANK, mer_pkg::ADDR_LOW_BLANK};
        end else begin
            stationAddress <= {addrHigh_reg, addrLow_reg};
        end
    end

    // ------------------------------------------------------------------
    // PHY management access
    // ------------------------------------------------------------------
    logic [4:0] phyAddr_reg;
    logic [4:0] regIndex_reg;
    logic writeNotRead_reg;
    logic busy_reg;
    logic [15:0] mgmtData_reg;
    logic accessWrite;
    logic startNow;
    assign accessWrite = wrNow & (address == mer_pkg::OFS_MGMT_ACCESS) & byteenable[0]
                         & byteenable[1];
    // Writes while busy are dropped; software must poll first
    assign startNow = accessWrite & ~busy_reg & writedata[mer_pkg::BIT_BUSY];

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            phyAddr_reg <= mer_pkg::PHYADDR_RESET;
            regIndex_reg <= '0;
            writeNotRead_reg <= 1'b0;
        end else if (accessWrite && !busy_reg) begin
            phyAddr_reg <= writedata[mer_pkg::PHYADDR_MSB:mer_pkg::PHYADDR_LSB];
            regIndex_reg <= writedata[mer_pkg::INDEX_MSB:mer_pkg::INDEX_LSB];
            writeNotRead_reg <= writedata[mer_pkg::BIT_WRITE_NOT_READ];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            busy_reg <= 1'b0;
        end else if (startNow) begin
            busy_reg <= 1'b1;
        end else if (mgmtDone) begin
            busy_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mgmtStart <= 1'b0;
            mgmtReq <= '0;
        end else begin
            mgmtStart <= startNow;
            if (startNow) begin
                mgmtReq.phyAddr <= writedata[mer_pkg::PHYADDR_MSB:mer_pkg::PHYADDR_LSB];
                mgmtReq.regIndex <= writedata[mer_pkg::INDEX_MSB:mer_pkg::INDEX_LSB];
                mgmtReq.writeNotRead <= writedata[mer_pkg::BIT_WRITE_NOT_READ];
                mgmtReq.writeData <= mgmtData_reg;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mgmtData_reg <= mer_pkg::DATA_RESET;
        end else if (busy_reg && mgmtDone && !writeNotRead_reg) begin
            mgmtData_reg <= mgmtReadData;
        end else if (wrNow && !busy_reg && address == mer_pkg::OFS_MGMT_DATA) begin
            mgmtData_reg <= (mgmtData_reg & ~wmask[15:0])
                            | (writedata[15:0] & wmask[15:0]);
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            readdata <= '0;
        end else if (accessNow && read) begin
            case (address)
                mer_pkg::OFS_ERR_FLAGS: readdata <= {22'h000000, errFlags_reg, 2'h0};
                mer_pkg::OFS_ADDR_HIGH: readdata <= {16'h0000, addrHigh_reg};
                mer_pkg::OFS_ADDR_LOW: readdata <= addrLow_reg;
                mer_pkg::OFS_MGMT_ACCESS: readdata <= {16'h0000, phyAddr_reg,
                    regIndex_reg, 4'h0, writeNotRead_reg, busy_reg};
                mer_pkg::OFS_MGMT_DATA: readdata <= {16'h0000, mgmtData_reg};
                default: readdata <= '0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Assertions: error flags and watchdog
    // ------------------------------------------------------------------
    rx_err_set_a: assert property (@(posedge clk_sys) disable iff (reset)
        macEvents.phyRxError && rxFrameActive |=> errFlags_reg[mer_pkg::BIT_PHY_RX_ERR])
        else $error("receive error flag not set");

    crc_flag_set_a: assert property (@(posedge clk_sys) disable iff (reset)
        macEvents.checksumError |=> errFlags_reg[mer_pkg::BIT_CHECKSUM])
        else $error("checksum flag not set");

    big_flag_set_a: assert property (@(posedge clk_sys) disable iff (reset)
        macEvents.oversizeFrame |=> errFlags_reg[mer_pkg::BIT_OVERSIZE])
        else $error("oversize flag not set");

    runt_flag_set_a: assert property (@(posedge clk_sys) disable iff (reset)
        macEvents.undersizeFrame |=> errFlags_reg[mer_pkg::BIT_UNDERSIZE])
        else $error("undersize flag not set");

    wdog_trunc_a: assert property (@(posedge clk_sys) disable iff (reset)
        watchdogHit |=> rxTruncate && errFlags_reg[mer_pkg::BIT_WATCHDOG])
        else $error("watchdog did not truncate");

    coll_flag_set_a: assert property (@(posedge clk_sys) disable iff (reset)
        macEvents.excessCollision |=> errFlags_reg[mer_pkg::BIT_EXCESS_COLL])
        else $error("collision flag not set");

    align_flag_set_a: assert property (@(posedge clk_sys) disable iff (reset)
        macEvents.misalignedFrame |=> errFlags_reg[mer_pkg::BIT_MISALIGNED])
        else $error("alignment flag not set");

    urun_flag_set_a: assert property (@(posedge clk_sys) disable iff (reset)
        macEvents.transmitUnderrun |=> errFlags_reg[mer_pkg::BIT_UNDERRUN])
        else $error("underrun flag not set");

    flag_sticky_a: assert property (@(posedge clk_sys) disable iff (reset)
        (errClear == '0) |=> ((errFlags_reg & $past(errFlags_reg)) == $past(errFlags_reg)))
        else $error("error flag dropped without clear");

    flag_set_wins_a: assert property (@(posedge clk_sys) disable iff (reset)
        errSet != '0 |=> (errFlags_reg & $past(errSet)) == $past(errSet))
        else $error("flag set lost to clear");

    flag_clear_a: assert property (@(posedge clk_sys) disable iff (reset)
        (errClear & ~errSet) != '0 |=> (errFlags_reg & $past(errClear & ~errSet)) == '0)
        else $error("written flag not cleared");

    trunc_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
        rxTruncate && rxFrameActive |=> rxTruncate)
        else $error("truncation dropped inside frame");

    trunc_end_a: assert property (@(posedge clk_sys) disable iff (reset)
        !rxFrameActive |=> !rxTruncate)
        else $error("truncation held after frame");

    // ------------------------------------------------------------------
    // Assertions: station address and management access
    // ------------------------------------------------------------------
    first_load_a: assert property (@(posedge clk_sys) disable iff (reset)
        !loadDone_reg |=> {addrHigh_reg, addrLow_reg} == $past(imageAddr))
        else $error("address image not loaded");

    usb_reload_a: assert property (@(posedge clk_sys) disable iff (reset)
        loadDone_reg && usbBusReset && !imagePresent |=> addrLow_reg == mer_pkg::ADDR_LOW_BLANK
        && addrHigh_reg == $past(addrHigh_reg))
        else $error("bus reset reload wrong");

    usb_image_a: assert property (@(posedge clk_sys) disable iff (reset)
        loadDone_reg && usbBusReset && imagePresent
        |=> {addrHigh_reg, addrLow_reg} == $past(imageAddr))
        else $error("bus reset image not restored");

    addr_track_a: assert property (@(posedge clk_sys) disable iff (reset)
        loadDone_reg |=> stationAddress == $past({addrHigh_reg, addrLow_reg}))
        else $error("station address out of step");

    busy_done_a: assert property (@(posedge clk_sys) disable iff (reset)
        busy_reg && mgmtDone && !startNow |=> !busy_reg)
        else $error("busy not cleared on completion");

    start_busy_a: assert property (@(posedge clk_sys) disable iff (reset)
        startNow |=> busy_reg && mgmtStart)
        else $error("access start lost");

    start_once_a: assert property (@(posedge clk_sys) disable iff (reset)
        mgmtStart |=> !mgmtStart)
        else $error("access start longer than one cycle");

    req_index_a: assert property (@(posedge clk_sys) disable iff (reset)
        startNow |=> mgmtReq.regIndex
        == $past(writedata[mer_pkg::INDEX_MSB:mer_pkg::INDEX_LSB]))
        else $error("register index not passed on");

    read_result_a: assert property (@(posedge clk_sys) disable iff (reset)
        busy_reg && mgmtDone && !writeNotRead_reg |=> mgmtData_reg == $past(mgmtReadData))
        else $error("read result not captured");

    busy_data_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
        busy_reg && !mgmtDone |=> mgmtData_reg == $past(mgmtData_reg))
        else $error("data register changed while busy");
endmodule

`default_nettype wire

// >>> sim/mer_phy_model.sv
// Behavioural PHY management partner for the register group.
// Assumes one access at a time, started by a one-cycle mgmtStart pulse.
`timescale 1ns/10ps
`default_nettype none
module mer_phy_model (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic mgmtStart,
    input wire mer_pkg::mer_mgmt_req_t mgmtReq,
    input wire logic [7:0] latency,
    output logic mgmtDone,
    output logic [15:0] mgmtReadData
);
    logic [15:0] phyRegs [0:31];
    logic [7:0] waitCnt;
    logic busy;
    mer_pkg::mer_mgmt_req_t held;
    // ------------------------------------------------------------------
    // Access engine
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            busy <= 1'h0;
            mgmtDone <= 1'h0;
            mgmtReadData <= 16'hA5A5;
        end else begin
            mgmtDone <= 1'h0;
            // Released data toggles so stale values never look valid
            mgmtReadData <= ~mgmtReadData;
            if (mgmtStart && !busy) begin
                busy <= 1'h1;
                held <= mgmtReq;
                waitCnt <= latency;
            end else if (busy && waitCnt != 8'h00) begin
                waitCnt <= waitCnt - 8'h01;
            end else if (busy) begin
                busy <= 1'h0;
                mgmtDone <= 1'h1;
                if (held.writeNotRead) begin
                    phyRegs[held.regIndex] <= held.writeData;
                end else begin
                    mgmtReadData <= phyRegs[held.regIndex];
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> sim/mer_regs_tb_top.sv
// Self-checking bench for the error flag, address and PHY access registers.
// Assumes the design pkg and the PHY partner model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module mer_regs_tb_top;
    localparam int LIMIT = 8;
    localparam logic [31:0] ONES = 32'hFFFFFFFF;
    logic clk_sys = 1'h0;
    logic reset = 1'h1;
    logic [11:0] address = 12'h000;
    logic read = 1'h0;
    logic write = 1'h0;
    logic [31:0] writedata = 32'h00000000;
    logic [31:0] readdata;
    logic waitrequest;
    mer_pkg::mer_events_t macEvents = '0;
    logic rxFrameActive = 1'h0;
    logic rxByteValid = 1'h0;
    logic rxTruncate;
    logic usbBusReset = 1'h0;
    mer_pkg::mer_src_t addrSource = mer_pkg::MER_SRC_NONE;
    logic [47:0] eepromAddress = 48'h000000000000;
    logic [47:0] otpAddress = 48'h000000000000;
    logic [47:0] stationAddress;
    logic mgmtStart;
    logic mgmtDone;
    mer_pkg::mer_mgmt_req_t mgmtReq;
    logic [15:0] mgmtReadData;
    logic [7:0] latency = 8'h00;
    logic [31:0] expQ [$];
    logic [31:0] maskQ [$];
    logic [31:0] lfsrState = 32'h00000026;
    logic [31:0] e;
    logic [31:0] m;
    int error_cnt = 0;
    int samples_checked = 0;

    always #2.5 clk_sys = ~clk_sys;

    mer_regs #(.WATCHDOG_LIMIT(LIMIT)) i_mer_regs (.clk_sys(clk_sys), .reset(reset),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest),
        .macEvents(macEvents), .rxFrameActive(rxFrameActive), .rxByteValid(rxByteValid),
        .rxTruncate(rxTruncate), .usbBusReset(usbBusReset), .addrSource(addrSource),
        .eepromAddress(eepromAddress), .otpAddress(otpAddress),
        .stationAddress(stationAddress), .mgmtStart(mgmtStart), .mgmtReq(mgmtReq),
        .mgmtDone(mgmtDone), .mgmtReadData(mgmtReadData));
    mer_phy_model i_mer_phy_model (.clk_sys(clk_sys), .reset(reset), .mgmtStart(mgmtStart),
        .mgmtReq(mgmtReq), .latency(latency), .mgmtDone(mgmtDone),
        .mgmtReadData(mgmtReadData));

    // ------------------------------------------------------------------
    // Checking and reporting
    // ------------------------------------------------------------------
    task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Read results are judged here, oldest note first
    always @(posedge clk_sys) begin
        if (read === 1'h1 && waitrequest === 1'h0) begin
            e = expQ.size() > 0 ? expQ.pop_front() : 32'h00000000;
            m = maskQ.size() > 0 ? maskQ.pop_front() : ONES;
            chk("readdata", e & m, readdata & m);
        end
    end

    // ------------------------------------------------------------------
    // Stimulus helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] rnd();
        lfsrState = {lfsrState[30:0], lfsrState[31] ^ lfsrState[21] ^ lfsrState[1] ^ lfsrState[0]};
        return lfsrState;
    endfunction
    // Mask zero marks a poll whose value is not predicted
    task automatic bus(input logic rnw, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] mk, output logic [31:0] q);
        int n;
        if (rnw) begin
            expQ.push_back(d);
            maskQ.push_back(mk);
        end
        @(posedge clk_sys);
        address <= a;
        read <= rnw;
        write <= !rnw;
        writedata <= rnw ? 32'h00000000 : d;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_sys);
            if (waitrequest === 1'h0) break;
        end
        if (n == 50) begin
            error_cnt++;
            finish_test();
        end
        q = readdata;
        read <= 1'h0;
        write <= 1'h0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'h1, a, d, ONES, q);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'h0, a, d, ONES, q);
    endtask
    task automatic poll();
        int n;
        logic [31:0] q;
        for (n = 0; n < 100; n++) begin
            bus(1'h1, mer_pkg::OFS_MGMT_ACCESS, 32'h00000000, 32'h00000000, q);
            if (q[0] === 1'h0) break;
        end
        if (n == 100) begin
            error_cnt++;
            finish_test();
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic pulse(input logic [7:0] ev);
        @(posedge clk_sys);
        macEvents <= ev;
        @(posedge clk_sys);
        macEvents <= '0;
    endtask
    task automatic byte_in();
        @(posedge clk_sys);
        rxByteValid <= 1'h1;
        @(posedge clk_sys);
        rxByteValid <= 1'h0;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [31:0] t;
        logic [31:0] u;
        logic [31:0] ex;
        logic [47:0] img;
        logic [4:0] idx [0:1];
        logic [15:0] val [0:1];
        for (int s = 0; s < 3; s++) begin
            t = rnd();
            u = rnd();
            eepromAddress <= {t[15:0], u};
            otpAddress <= {u[15:0], t};
            addrSource <= mer_pkg::mer_src_t'(s[1:0]);
            reset <= 1'h1;
            tick(6);
            reset <= 1'h0;
            tick(3);
            img = s == 2 ? eepromAddress : (s == 1 ? otpAddress : {16'hFFFF, ONES});
            rd(mer_pkg::OFS_ADDR_HIGH, {16'h0000, img[47:32]});
            rd(mer_pkg::OFS_ADDR_LOW, img[31:0]);
            chk("stationAddress", img, stationAddress);
            t = rnd();
            wr(mer_pkg::OFS_ADDR_HIGH, t);
            wr(mer_pkg::OFS_ADDR_LOW, ~t);
            rd(mer_pkg::OFS_ADDR_HIGH, {16'h0000, t[15:0]});
            chk("stationAddress", {t[15:0], ~t}, stationAddress);
            @(posedge clk_sys);
            usbBusReset <= 1'h1;
            @(posedge clk_sys);
            usbBusReset <= 1'h0;
            rd(mer_pkg::OFS_ADDR_HIGH, {16'h0000, s == 0 ? t[15:0] : img[47:32]});
            rd(mer_pkg::OFS_ADDR_LOW, s == 0 ? ONES : img[31:0]);
        end
        $display("test address image done");
        rd(mer_pkg::OFS_ERR_FLAGS, 32'h00000000);
        pulse(8'h80);
        rd(mer_pkg::OFS_ERR_FLAGS, 32'h00000000);
        rxFrameActive <= 1'h1;
        pulse(8'h80);
        ex = 32'h00000200;
        rd(mer_pkg::OFS_ERR_FLAGS, ex);
        for (int i = 0; i < 7; i++) begin
            pulse(8'h01 << i);
            ex = ex | (32'h00000004 << i);
            rd(mer_pkg::OFS_ERR_FLAGS, ex);
        end
        wr(mer_pkg::OFS_ERR_FLAGS, 32'h00000120);
        rd(mer_pkg::OFS_ERR_FLAGS, ex & ~32'h00000120);
        wr(mer_pkg::OFS_ERR_FLAGS, ONES);
        rd(mer_pkg::OFS_ERR_FLAGS, 32'h00000000);
        $display("test error flags done");
        repeat (LIMIT) byte_in();
        tick(1);
        chk("rxTruncate", 48'h0, {47'h0, rxTruncate});
        byte_in();
        tick(1);
        chk("rxTruncate", 48'h1, {47'h0, rxTruncate});
        rd(mer_pkg::OFS_ERR_FLAGS, 32'h00000020);
        rxFrameActive <= 1'h0;
        tick(3);
        chk("rxTruncate", 48'h0, {47'h0, rxTruncate});
        $display("test watchdog done");
        for (int k = 0; k < 2; k++) begin
            latency <= k == 1 ? 8'h14 : 8'h00;
            t = rnd();
            idx[k] = k == 1 ? ~idx[0] : t[4:0];
            val[k] = t[31:16];
            wr(mer_pkg::OFS_MGMT_DATA, {16'h0000, val[k]});
            wr(mer_pkg::OFS_MGMT_ACCESS, {16'h0000, 5'h01, idx[k], 6'h03});
            if (k == 1) begin
                rd(mer_pkg::OFS_MGMT_ACCESS, {16'h0000, 5'h01, idx[k], 6'h03});
                wr(mer_pkg::OFS_MGMT_DATA, ~t);
            end
            poll();
            rd(mer_pkg::OFS_MGMT_DATA, {16'h0000, val[k]});
            wr(mer_pkg::OFS_MGMT_DATA, 32'h00000000);
            wr(mer_pkg::OFS_MGMT_ACCESS, {16'h0000, 5'h01, idx[k], 6'h01});
            poll();
            rd(mer_pkg::OFS_MGMT_DATA, {16'h0000, val[k]});
            rd(mer_pkg::OFS_MGMT_ACCESS, {16'h0000, 5'h01, idx[k], 6'h00});
        end
        wr(mer_pkg::OFS_MGMT_ACCESS, {16'h0000, 5'h01, idx[0], 6'h01});
        poll();
        rd(mer_pkg::OFS_MGMT_DATA, {16'h0000, val[0]});
        $display("test phy management done");
        wr(12'h128, ONES);
        rd(12'h128, 32'h00000000);
        $display("test unmapped done");
        finish_test();
    end
endmodule
`default_nettype wire
